// ===== ll_addr_gen.sv
// Effective address and alignment check for linked loads
`include "ll_exec_defs.svh"

module ll_addr_gen (
   // Operation
   input wire ll_exec_pkg::ll_op_t op_i,
   input wire logic [31:0] base_i,
   input wire logic [`LL_OFFSET_W-1:0] offset_i,
   // Result
   output logic [31:0] vaddr_o,
   output logic misaligned_o
);

   logic [31:0] offset_ext;

   always_comb begin
      offset_ext = {{(32-`LL_OFFSET_W){offset_i[`LL_OFFSET_W-1]}}, offset_i};
      if (ll_exec_pkg::is_paired(op_i)) begin
         // Paired form has no offset
         vaddr_o = base_i;
         misaligned_o = |(base_i & `LL_PAIR_ALIGN_MASK);
      end else begin
         vaddr_o = base_i + offset_ext;
         misaligned_o = |((base_i + offset_ext) & `LL_WORD_ALIGN_MASK);
      end
   end

endmodule : ll_addr_gen

// ===== ll_exec_defs.svh
// Constants for the load-linked execution unit
`ifndef LL_EXEC_DEFS_SVH
`define LL_EXEC_DEFS_SVH

`define LL_OFFSET_W 9
`define LL_WORD_ALIGN_MASK 32'h0000_0003
`define LL_PAIR_ALIGN_MASK 32'h0000_0007
`define LL_ZERO_REG 5'h00
`define LL_LINK_ADDR_RESET 32'h0000_0000

`endif

// ===== ll_exec_pkg.sv
// Types and decode helpers for the load-linked execution unit
package ll_exec_pkg;

   typedef enum logic [1:0] {
      OP_USER_WORD = 2'b00,
      OP_PAIRED = 2'b01,
      OP_USER_PAIRED = 2'b10,
      OP_ILLEGAL = 2'b11
   } ll_op_t;

   typedef enum logic [2:0] {
      EXC_NONE = 3'b000,
      EXC_TLB_REFILL = 3'b001,
      EXC_TLB_INVALID = 3'b010,
      EXC_ADDR_ERROR = 3'b011,
      EXC_RESERVED_INSTR = 3'b100,
      EXC_WATCH = 3'b101,
      EXC_COP_UNUSABLE = 3'b110
   } exc_code_t;

   typedef enum logic [1:0] {
      SEG_UNMAPPED_SUP_KERNEL = 2'b00,
      SEG_MAPPED_SUP_KERNEL = 2'b01,
      SEG_MAPPED_USER_KERNEL = 2'b10,
      SEG_KERNEL_ONLY = 2'b11
   } seg_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_XLAT = 2'b01,
      ST_MEM = 2'b10
   } ll_state_t;

   function automatic logic is_paired(input ll_op_t op);
      is_paired = (op == OP_PAIRED) || (op == OP_USER_PAIRED);
   endfunction : is_paired

   function automatic logic is_user_space(input ll_op_t op);
      is_user_space = (op == OP_USER_WORD) || (op == OP_USER_PAIRED);
   endfunction : is_user_space

endpackage : ll_exec_pkg

// ===== ll_far_side_model.sv
// Translation and memory model facing the load-linked unit
module ll_far_side_model #(
   parameter logic [31:0] XOR_MASK = 32'h4000_0000
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bench control
   input wire logic slow_i,
   input wire ll_exec_pkg::seg_mode_t seg_i,
   input wire logic [1:0] fault_i,
   // Translation
   input wire logic xlat_req_i,
   input wire logic [31:0] xlat_vaddr_i,
   output logic xlat_ack_o,
   output logic [31:0] xlat_paddr_o,
   output ll_exec_pkg::seg_mode_t xlat_seg_mode_o,
   output logic xlat_refill_o,
   output logic xlat_invalid_o,
   output logic xlat_watch_o,
   // Memory
   input wire logic mem_req_i,
   input wire logic [31:0] mem_addr_i,
   output logic mem_ack_o,
   output logic [63:0] mem_rdata_o
);
   logic [1:0] wait_reg;
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      xlat_ack_o <= 1'b0;
      mem_ack_o <= 1'b0;
      // Stale address, segment and data lines invert every cycle, so a sample one cycle late never matches
      xlat_paddr_o <= ~xlat_paddr_o;
      xlat_seg_mode_o <= ll_exec_pkg::seg_mode_t'(~xlat_seg_mode_o);
      mem_rdata_o <= ~mem_rdata_o;
      if (rst_i) begin
         wait_reg <= 2'h0;
         xlat_paddr_o <= 32'h0000_0000;
         xlat_seg_mode_o <= ll_exec_pkg::SEG_UNMAPPED_SUP_KERNEL;
         mem_rdata_o <= 64'h0000_0000_0000_0000;
      end else if ((xlat_req_i && !xlat_ack_o) || (mem_req_i && !mem_ack_o)) begin
         if (wait_reg >= (slow_i ? 2'h3 : 2'h0)) begin
            wait_reg <= 2'h0;
            if (xlat_req_i) begin
               xlat_ack_o <= 1'b1;
               xlat_paddr_o <= xlat_vaddr_i ^ XOR_MASK;
               xlat_seg_mode_o <= seg_i;
               xlat_refill_o <= fault_i == 2'h1;
               xlat_invalid_o <= fault_i == 2'h2;
               xlat_watch_o <= fault_i == 2'h3;
            end else begin
               // Every location answers as synchronizable
               mem_ack_o <= 1'b1;
               mem_rdata_o <= {mem_addr_i ^ 32'h0F0F_A5A5, ~mem_addr_i};
            end
         end else begin
            wait_reg <= wait_reg + 2'h1;
         end
      end
   end
endmodule : ll_far_side_model

// ===== ll_link_state.sv
// Link flag and linked-address register
`include "ll_exec_defs.svh"

module ll_link_state (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic set_i,
   input wire logic [31:0] set_addr_i,
   input wire logic clear_i,
   // State
   output logic link_flag_o,
   output logic [31:0] linked_addr_o
);

   logic [31:1] addr_reg;
   logic [31:1] addr_next;
   logic flag_reg;
   logic flag_next;
   localparam logic [31:0] LINK_ADDR_RESET = `LL_LINK_ADDR_RESET;

   always_comb begin
      addr_next = addr_reg;
      flag_next = flag_reg;
      // Set beats a clear in the same cycle
      if (clear_i) begin
         flag_next = 1'b0;
      end
      if (set_i) begin
         flag_next = 1'b1;
         addr_next = set_addr_i[31:1];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_reg <= LINK_ADDR_RESET[31:1];
         flag_reg <= 1'b0;
      end else begin
         addr_reg <= addr_next;
         flag_reg <= flag_next;
      end
   end

   assign link_flag_o = flag_reg;
   assign linked_addr_o = {addr_reg, flag_reg};

endmodule : ll_link_state

// ===== load_linked_execution_unit.sv
// Execution unit for the word and paired linked loads
`include "ll_exec_defs.svh"

// How it works
// - Word address is base plus sign-extended 9-bit offset; paired address is base alone.
// - Aligned word fetched and written to target_reg.
// - Low two address bits nonzero raise address error.
// - One sequence; each linked load restarts it.
// - Linked load sends nothing to other processors.
// - Abandoned sequence never touches memory.
// - User-space ops use user map, three segments.
// - User word load needs enhanced addressing enabled.
// - Location must be synchronizable by all sharers.
// - Paired reads 64 bits; low target, high second.
// - Paired success sets flag and records address.
// - Recorded paired address is doubleword aligned.
// - Paired load needs no-extended-pair flag zero.
// - User paired needs flag zero and addressing one.
// - Zero destinations still open a sequence.
// - User word exceptions include coprocessor unusable.
// - Paired exceptions: refill, invalid, RI, AE, watch.
module load_linked_execution_unit (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Configuration
   input wire logic enhanced_virtual_addressing_i,
   input wire logic no_extended_pair_flag_i,
   input wire logic cop0_usable_i,
   // Issue from pipeline
   input wire logic issue_valid_i,
   input wire ll_exec_pkg::ll_op_t issue_op_i,
   input wire logic [31:0] base_i,
   input wire logic [`LL_OFFSET_W-1:0] offset_i,
   input wire logic [4:0] target_reg_i,
   input wire logic [4:0] second_reg_i,
   output logic busy_o,
   // Link clear from elsewhere in the core
   input wire logic link_clear_i,
   // Address translation
   output logic xlat_req_o,
   output logic [31:0] xlat_vaddr_o,
   output logic xlat_user_map_o,
   input wire logic xlat_ack_i,
   input wire logic [31:0] xlat_paddr_i,
   input wire ll_exec_pkg::seg_mode_t xlat_seg_mode_i,
   input wire logic xlat_refill_i,
   input wire logic xlat_invalid_i,
   input wire logic xlat_watch_i,
   // Memory read
   output logic mem_req_o,
   output logic [31:0] mem_addr_o,
   output logic mem_pair_o,
   input wire logic mem_ack_i,
   input wire logic [63:0] mem_rdata_i,
   // Register writeback
   output logic wb_valid_o,
   output logic [4:0] wb_reg_o,
   output logic [31:0] wb_data_o,
   output logic wb2_valid_o,
   output logic [4:0] wb2_reg_o,
   output logic [31:0] wb2_data_o,
   // Exception
   output logic exc_valid_o,
   output ll_exec_pkg::exc_code_t exc_code_o,
   // Link state
   output logic link_flag_o,
   output logic [31:0] linked_addr_o
);

   ////////////////////////////////////////////////////////////////////////
   logic [31:0] vaddr;
   logic misaligned;
   logic link_set;
   logic issue_take;
   ll_exec_pkg::exc_code_t issue_exc;

   ll_exec_pkg::ll_state_t state_reg, state_next;
   ll_exec_pkg::ll_op_t op_reg, op_next;
   logic [4:0] dst_reg, dst_next;
   logic [4:0] rd_reg, rd_next;
   logic busy_reg, busy_next;
   logic xreq_reg, xreq_next;
   logic [31:0] xvaddr_reg, xvaddr_next;
   logic xuser_reg, xuser_next;
   logic mreq_reg, mreq_next;
   logic [31:0] maddr_reg, maddr_next;
   logic mpair_reg, mpair_next;
   logic wb_reg, wb_next;
   logic [31:0] wbd_reg, wbd_next;
   logic wb2_reg, wb2_next;
   logic [31:0] wb2d_reg, wb2d_next;
   logic exc_reg, exc_next;
   ll_exec_pkg::exc_code_t code_reg, code_next;

   ll_addr_gen u_addr (
      .op_i(issue_op_i),
      .base_i(base_i),
      .offset_i(offset_i),
      .vaddr_o(vaddr),
      .misaligned_o(misaligned)
   );

   // Only set after a clean memory return, so faults leave it alone
   ll_link_state u_link (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(link_set),
      .set_addr_i(maddr_reg),
      .clear_i(link_clear_i),
      .link_flag_o(link_flag_o),
      .linked_addr_o(linked_addr_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // Early checks, in priority order
   always_comb begin
      issue_exc = ll_exec_pkg::EXC_NONE;
      unique case (issue_op_i)
         ll_exec_pkg::OP_USER_WORD: begin
            if (!enhanced_virtual_addressing_i) begin
               issue_exc = ll_exec_pkg::EXC_RESERVED_INSTR;
            end else if (!cop0_usable_i) begin
               issue_exc = ll_exec_pkg::EXC_COP_UNUSABLE;
            end else if (misaligned) begin
               issue_exc = ll_exec_pkg::EXC_ADDR_ERROR;
            end
         end
         ll_exec_pkg::OP_PAIRED: begin
            if (no_extended_pair_flag_i) begin
               issue_exc = ll_exec_pkg::EXC_RESERVED_INSTR;
            end else if (misaligned) begin
               issue_exc = ll_exec_pkg::EXC_ADDR_ERROR;
            end
         end
         ll_exec_pkg::OP_USER_PAIRED: begin
            if (no_extended_pair_flag_i || !enhanced_virtual_addressing_i) begin
               issue_exc = ll_exec_pkg::EXC_RESERVED_INSTR;
            end else if (!cop0_usable_i) begin
               issue_exc = ll_exec_pkg::EXC_COP_UNUSABLE;
            end else if (misaligned) begin
               issue_exc = ll_exec_pkg::EXC_ADDR_ERROR;
            end
         end
         default: begin
            issue_exc = ll_exec_pkg::EXC_RESERVED_INSTR;
         end
      endcase
   end

   assign issue_take = issue_valid_i && (state_reg == ll_exec_pkg::ST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      op_next = op_reg;
      dst_next = dst_reg;
      rd_next = rd_reg;
      busy_next = busy_reg;
      xreq_next = xreq_reg;
      xvaddr_next = xvaddr_reg;
      xuser_next = xuser_reg;
      mreq_next = mreq_reg;
      maddr_next = maddr_reg;
      mpair_next = mpair_reg;
      wb_next = 1'b0;
      wbd_next = wbd_reg;
      wb2_next = 1'b0;
      wb2d_next = wb2d_reg;
      exc_next = 1'b0;
      code_next = code_reg;
      link_set = 1'b0;
      unique case (state_reg)
         ll_exec_pkg::ST_IDLE: begin
            if (issue_take) begin
               op_next = issue_op_i;
               dst_next = target_reg_i;
               rd_next = second_reg_i;
               if (issue_exc != ll_exec_pkg::EXC_NONE) begin
                  // No translation, no read, no writeback
                  exc_next = 1'b1;
                  code_next = issue_exc;
               end else begin
                  state_next = ll_exec_pkg::ST_XLAT;
                  busy_next = 1'b1;
                  xreq_next = 1'b1;
                  xvaddr_next = vaddr;
                  xuser_next = ll_exec_pkg::is_user_space(issue_op_i);
               end
            end
         end
         ll_exec_pkg::ST_XLAT: begin
            if (xlat_ack_i) begin
               xreq_next = 1'b0;
               if (xuser_reg && xlat_seg_mode_i == ll_exec_pkg::SEG_KERNEL_ONLY) begin
                  exc_next = 1'b1;
                  code_next = ll_exec_pkg::EXC_ADDR_ERROR;
               end else if (xlat_refill_i) begin
                  exc_next = 1'b1;
                  code_next = ll_exec_pkg::EXC_TLB_REFILL;
               end else if (xlat_invalid_i) begin
                  exc_next = 1'b1;
                  code_next = ll_exec_pkg::EXC_TLB_INVALID;
               end else if (xlat_watch_i) begin
                  exc_next = 1'b1;
                  code_next = ll_exec_pkg::EXC_WATCH;
               end
               if (exc_next) begin
                  state_next = ll_exec_pkg::ST_IDLE;
                  busy_next = 1'b0;
               end else begin
                  // Read only: the unit has no memory write path at all
                  state_next = ll_exec_pkg::ST_MEM;
                  mreq_next = 1'b1;
                  maddr_next = ll_exec_pkg::is_paired(op_reg) ? {xlat_paddr_i[31:3], 3'h0} : xlat_paddr_i;
                  mpair_next = ll_exec_pkg::is_paired(op_reg);
               end
            end
         end
         ll_exec_pkg::ST_MEM: begin
            if (mem_ack_i) begin
               state_next = ll_exec_pkg::ST_IDLE;
               busy_next = 1'b0;
               mreq_next = 1'b0;
               // Writes to register zero are still issued; file ignores them
               wb_next = 1'b1;
               wbd_next = mem_rdata_i[31:0];
               wb2_next = mpair_reg;
               wb2d_next = mem_rdata_i[63:32];
               // Link opens even with both destinations zero
               link_set = 1'b1;
            end
         end
         default: begin
            state_next = ll_exec_pkg::ST_IDLE;
            busy_next = 1'b0;
            xreq_next = 1'b0;
            mreq_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ll_exec_pkg::ST_IDLE;
         op_reg <= ll_exec_pkg::OP_USER_WORD;
         dst_reg <= `LL_ZERO_REG;
         rd_reg <= `LL_ZERO_REG;
         busy_reg <= 1'b0;
         xreq_reg <= 1'b0;
         xvaddr_reg <= 32'h0000_0000;
         xuser_reg <= 1'b0;
         mreq_reg <= 1'b0;
         maddr_reg <= 32'h0000_0000;
         mpair_reg <= 1'b0;
         wb_reg <= 1'b0;
         wbd_reg <= 32'h0000_0000;
         wb2_reg <= 1'b0;
         wb2d_reg <= 32'h0000_0000;
         exc_reg <= 1'b0;
         code_reg <= ll_exec_pkg::EXC_NONE;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         dst_reg <= dst_next;
         rd_reg <= rd_next;
         busy_reg <= busy_next;
         xreq_reg <= xreq_next;
         xvaddr_reg <= xvaddr_next;
         xuser_reg <= xuser_next;
         mreq_reg <= mreq_next;
         maddr_reg <= maddr_next;
         mpair_reg <= mpair_next;
         wb_reg <= wb_next;
         wbd_reg <= wbd_next;
         wb2_reg <= wb2_next;
         wb2d_reg <= wb2d_next;
         exc_reg <= exc_next;
         code_reg <= code_next;
      end
   end

   // Nothing is broadcast outward, so remote links are never disturbed
   assign busy_o = busy_reg;
   assign xlat_req_o = xreq_reg;
   assign xlat_vaddr_o = xvaddr_reg;
   assign xlat_user_map_o = xuser_reg;
   assign mem_req_o = mreq_reg;
   assign mem_addr_o = maddr_reg;
   assign mem_pair_o = mpair_reg;
   assign wb_valid_o = wb_reg;
   assign wb_reg_o = dst_reg;
   assign wb_data_o = wbd_reg;
   assign wb2_valid_o = wb2_reg;
   assign wb2_reg_o = rd_reg;
   assign wb2_data_o = wb2d_reg;
   assign exc_valid_o = exc_reg;
   assign exc_code_o = code_reg;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_MISALIGN_WORD: assert property (
      issue_take && issue_op_i == ll_exec_pkg::OP_USER_WORD && enhanced_virtual_addressing_i
      && cop0_usable_i && misaligned |=> exc_valid_o && exc_code_o == ll_exec_pkg::EXC_ADDR_ERROR
      && !xlat_req_o) else $error("misaligned word load not faulted");
   AST_FAULT_KEEPS_LINK: assert property (
      exc_valid_o |-> $stable(linked_addr_o) && !wb_valid_o && !mem_req_o)
      else $error("fault disturbed link or writeback");
   AST_NO_EVA_RI: assert property (
      issue_take && issue_op_i == ll_exec_pkg::OP_USER_WORD && !enhanced_virtual_addressing_i
      |=> exc_code_o == ll_exec_pkg::EXC_RESERVED_INSTR) else $error("missing reserved instruction");
   AST_XNP_RI: assert property (
      issue_take && issue_op_i == ll_exec_pkg::OP_PAIRED && no_extended_pair_flag_i
      |=> exc_valid_o && exc_code_o == ll_exec_pkg::EXC_RESERVED_INSTR) else $error("paired not refused");
   AST_EA_FORMED: assert property (
      issue_take && issue_exc == ll_exec_pkg::EXC_NONE |=> xlat_req_o && xlat_vaddr_o == $past(vaddr)
      && xlat_user_map_o == $past(ll_exec_pkg::is_user_space(issue_op_i)))
      else $error("effective address wrong");
   AST_LOW_WORD: assert property (
      mem_req_o && mem_ack_i |=> wb_valid_o && wb_data_o == $past(mem_rdata_i[31:0]) && link_flag_o)
      else $error("low word or link flag wrong");
   AST_HIGH_WORD: assert property (
      mem_req_o && mem_ack_i && mem_pair_o |=> wb2_valid_o && wb2_data_o == $past(mem_rdata_i[63:32]))
      else $error("high word wrong");
   AST_LINK_ADDR: assert property (
      mem_req_o && mem_ack_i |=> linked_addr_o[31:1] == $past(mem_addr_o[31:1]))
      else $error("linked address not recorded");
   AST_PAIR_ALIGNED: assert property (
      wb2_valid_o |-> linked_addr_o[2:1] == 2'b00) else $error("paired link address misaligned");

   COV_WORD_DONE: cover property (wb_valid_o && !wb2_valid_o);
   COV_PAIR_DONE: cover property (wb2_valid_o);
   COV_TLB_FAULT: cover property (exc_valid_o && exc_code_o == ll_exec_pkg::EXC_TLB_REFILL);
   COV_SET_CLEAR: cover property (link_set && link_clear_i);

endmodule : load_linked_execution_unit

// ===== load_linked_execution_unit_tb.sv
// Self-checking bench for the load-linked execution unit
module load_linked_execution_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] XOR_MASK = 32'h4000_0000;
   logic clk_i = 0, rst_i = 1, enhanced_virtual_addressing_i = 0, no_extended_pair_flag_i = 0;
   logic cop0_usable_i = 0, issue_valid_i = 0, link_clear_i = 0, slow = 0;
   ll_exec_pkg::ll_op_t issue_op_i = ll_exec_pkg::OP_USER_WORD;
   logic [31:0] base_i = 0, xlat_vaddr_o, xlat_paddr_i, mem_addr_o, wb_data_o, wb2_data_o, linked_addr_o;
   logic [8:0] offset_i = 0;
   logic [4:0] target_reg_i = 0, second_reg_i = 0, wb_reg_o, wb2_reg_o;
   logic busy_o, xlat_req_o, xlat_user_map_o, xlat_ack_i, xlat_refill_i, xlat_invalid_i, xlat_watch_i;
   logic mem_req_o, mem_pair_o, mem_ack_i, wb_valid_o, wb2_valid_o, exc_valid_o, link_flag_o;
   ll_exec_pkg::seg_mode_t xlat_seg_mode_i, seg = ll_exec_pkg::SEG_UNMAPPED_SUP_KERNEL;
   ll_exec_pkg::exc_code_t exc_code_o;
   logic [63:0] mem_rdata_i;
   logic [1:0] fault = 0;
   logic ext_addr, no_pair, cop;
   logic [31:0] exp_la = 0;
   int err_count = 0, comparisons = 0, cycles = 0;
   ////////////////////////////////////////////////////////////////
   load_linked_execution_unit dut (.clk_i, .rst_i, .enhanced_virtual_addressing_i, .no_extended_pair_flag_i,
      .cop0_usable_i, .issue_valid_i, .issue_op_i, .base_i, .offset_i, .target_reg_i, .second_reg_i, .busy_o,
      .link_clear_i, .xlat_req_o, .xlat_vaddr_o, .xlat_user_map_o, .xlat_ack_i, .xlat_paddr_i, .xlat_seg_mode_i,
      .xlat_refill_i, .xlat_invalid_i, .xlat_watch_i, .mem_req_o, .mem_addr_o, .mem_pair_o, .mem_ack_i,
      .mem_rdata_i, .wb_valid_o, .wb_reg_o, .wb_data_o, .wb2_valid_o, .wb2_reg_o, .wb2_data_o, .exc_valid_o,
      .exc_code_o, .link_flag_o, .linked_addr_o);
   ll_far_side_model #(.XOR_MASK(XOR_MASK)) far (.clk_i, .rst_i, .slow_i(slow), .seg_i(seg), .fault_i(fault),
      .xlat_req_i(xlat_req_o), .xlat_vaddr_i(xlat_vaddr_o), .xlat_ack_o(xlat_ack_i), .xlat_paddr_o(xlat_paddr_i),
      .xlat_seg_mode_o(xlat_seg_mode_i), .xlat_refill_o(xlat_refill_i), .xlat_invalid_o(xlat_invalid_i),
      .xlat_watch_o(xlat_watch_i), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i),
      .mem_rdata_o(mem_rdata_i));
   ////////////////////////////////////////////////////////////////
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         give_verdict;
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   function automatic ll_exec_pkg::exc_code_t exp_exc(input ll_exec_pkg::ll_op_t op, input logic [31:0] va);
      logic usr;
      usr = op == ll_exec_pkg::OP_USER_WORD || op == ll_exec_pkg::OP_USER_PAIRED;
      if (op == ll_exec_pkg::OP_ILLEGAL || (op != ll_exec_pkg::OP_USER_WORD && no_pair) || (usr && !ext_addr))
         return ll_exec_pkg::EXC_RESERVED_INSTR;
      if (usr && !cop) return ll_exec_pkg::EXC_COP_UNUSABLE;
      if (op == ll_exec_pkg::OP_USER_WORD ? va[1:0] != 2'h0 : va[2:0] != 3'h0)
         return ll_exec_pkg::EXC_ADDR_ERROR;
      if (usr && seg == ll_exec_pkg::SEG_KERNEL_ONLY) return ll_exec_pkg::EXC_ADDR_ERROR;
      if (fault == 2'h1) return ll_exec_pkg::EXC_TLB_REFILL;
      if (fault == 2'h2) return ll_exec_pkg::EXC_TLB_INVALID;
      if (fault == 2'h3) return ll_exec_pkg::EXC_WATCH;
      return ll_exec_pkg::EXC_NONE;
   endfunction : exp_exc
   task automatic run_op(input ll_exec_pkg::ll_op_t op, input logic [31:0] base, input logic [8:0] off,
                         input logic [4:0] tr, input logic [4:0] sr);
      logic [31:0] va, pa;
      logic [63:0] md;
      ll_exec_pkg::exc_code_t ee;
      logic mem_seen, done, word;
      word = op == ll_exec_pkg::OP_USER_WORD;
      va = word ? base + {{23{off[8]}}, off} : base;
      pa = va ^ XOR_MASK;
      md = {pa ^ 32'h0F0F_A5A5, ~pa};
      ee = exp_exc(op, va);
      mem_seen = 0;
      done = 0;
      @(posedge clk_i);
      enhanced_virtual_addressing_i <= ext_addr;
      no_extended_pair_flag_i <= no_pair;
      cop0_usable_i <= cop;
      issue_valid_i <= 1;
      issue_op_i <= op;
      base_i <= base;
      offset_i <= off;
      target_reg_i <= tr;
      second_reg_i <= sr;
      @(posedge clk_i);
      issue_valid_i <= 0;
      for (int n = 0; n < 40 && !done; n++) begin
         #1;
         if (xlat_req_o === 1'b1) begin
            chk(xlat_vaddr_o, va);
            chk(xlat_user_map_o, op != ll_exec_pkg::OP_PAIRED);
         end
         if (mem_req_o === 1'b1) begin
            mem_seen = 1;
            chk({mem_pair_o, mem_addr_o}, {!word, pa});
         end
         if (exc_valid_o === 1'b1 || wb_valid_o === 1'b1) done = 1;
         else @(posedge clk_i);
      end
      chk(done, 1);
      chk(exc_valid_o, ee != ll_exec_pkg::EXC_NONE);
      chk(mem_seen, ee == ll_exec_pkg::EXC_NONE);
      if (ee != ll_exec_pkg::EXC_NONE) chk(exc_code_o, ee);
      else begin
         chk({wb_reg_o, wb_data_o}, {tr, md[31:0]});
         chk(wb2_valid_o, !word);
         if (!word) chk({wb2_reg_o, wb2_data_o}, {sr, md[63:32]});
         exp_la = {pa[31:1], 1'b1};
      end
      chk({link_flag_o, linked_addr_o}, {exp_la[0], exp_la});
   endtask : run_op
   ////////////////////////////////////////////////////////////////
   initial begin
      ll_exec_pkg::ll_op_t op;
      logic [1:0] opc;
      logic [31:0] base;
      logic [8:0] off;
      void'($urandom(58309));
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      #1 chk({busy_o, exc_valid_o, link_flag_o, linked_addr_o}, 0);
      for (int i = 0; i < 300; i++) begin
         opc = 2'($urandom);
         base = $urandom;
         off = 9'($urandom);
         if ($urandom % 4 != 0) base[2:0] = 3'h0;
         if ($urandom % 4 != 0) off[1:0] = 2'h0;
         ext_addr = $urandom % 8 != 0;
         no_pair = $urandom % 8 == 0;
         cop = $urandom % 8 != 0;
         seg = ll_exec_pkg::seg_mode_t'(2'($urandom));
         fault = ($urandom % 4 == 0) ? 2'($urandom) : 2'h0;
         slow = 1'($urandom);
         // Hand-picked corners first: offset extremes, zero destinations, misalignment
         if (i < 6) begin
            // Paired forms present here, so the aligned pair corners really reach memory
            {ext_addr, no_pair, cop, fault} = 5'h14;
            seg = ll_exec_pkg::SEG_MAPPED_USER_KERNEL;
            case (i)
               0: {opc, base, off} = {ll_exec_pkg::OP_USER_WORD, 32'h0000_1100, 9'h100};
               1: {opc, base, off} = {ll_exec_pkg::OP_USER_WORD, 32'h0000_1000, 9'h0FC};
               2: {opc, base, off} = {ll_exec_pkg::OP_PAIRED, 32'h0000_2008, 9'h000};
               3: {opc, base, off} = {ll_exec_pkg::OP_USER_PAIRED, 32'h0000_3010, 9'h000};
               4: {opc, base, off} = {ll_exec_pkg::OP_USER_WORD, 32'h0000_1000, 9'h002};
               default: {opc, base, off} = {ll_exec_pkg::OP_PAIRED, 32'h0000_2004, 9'h000};
            endcase
         end
         // Abandoned sequences are simply replaced or cleared
         if ($urandom % 5 == 0) begin
            @(posedge clk_i);
            link_clear_i <= 1;
            @(posedge clk_i);
            link_clear_i <= 0;
            exp_la[0] = 1'b0;
            #1 chk({link_flag_o, linked_addr_o}, {1'b0, exp_la});
         end
         op = ll_exec_pkg::ll_op_t'(opc);
         run_op(op, base, off, (i == 2) ? 5'h00 : 5'($urandom), (i == 2) ? 5'h00 : 5'($urandom));
      end
      give_verdict;
   end
endmodule : load_linked_execution_unit_tb
